// ==== rtl/bst_pkg.sv ====
// boundary-scan test port: shared constants, instruction codes and tap states.
// assumes a single test clock domain for the tap and a separate system clock for pins.
package bst_pkg;

  localparam int BST_IR_W = 3;
  localparam int BST_ID_W = 32;

  localparam logic [2:0] BST_IR_EXTEST = 3'h0;
  localparam logic [2:0] BST_IR_IDCODE = 3'h1;
  localparam logic [2:0] BST_IR_SAMPLE = 3'h2;
  localparam logic [2:0] BST_IR_HIGHZ = 3'h3;
  localparam logic [2:0] BST_IR_CLAMP = 3'h4;
  localparam logic [2:0] BST_IR_BYPASS = 3'h7;

  // instruction register capture pattern, two lsbs fixed at 01
  localparam logic [2:0] BST_IR_CAPTURE = 3'h1;

  // identification word field positions
  localparam int BST_ID_VER_LSB = 28;
  localparam int BST_ID_PART_LSB = 12;
  localparam int BST_ID_MFR_LSB = 1;
  localparam logic BST_ID_LSB_VAL = 1'h1;

  // reset values
  localparam logic BST_TDO_RST = 1'h0;
  localparam logic BST_PIN_RST = 1'h0;

  typedef enum logic [3:0] {
    BST_TLR = 4'h0,
    BST_RTI = 4'h1,
    BST_SEL_DR = 4'h2,
    BST_CAP_DR = 4'h3,
    BST_SHF_DR = 4'h4,
    BST_EX1_DR = 4'h5,
    BST_PAU_DR = 4'h6,
    BST_EX2_DR = 4'h7,
    BST_UPD_DR = 4'h8,
    BST_SEL_IR = 4'h9,
    BST_CAP_IR = 4'ha,
    BST_SHF_IR = 4'hb,
    BST_EX1_IR = 4'hc,
    BST_PAU_IR = 4'hd,
    BST_EX2_IR = 4'he,
    BST_UPD_IR = 4'hf
  } bst_state_t;

endpackage : bst_pkg

// ==== rtl/bst_sync.sv ====
// two-flop level synchroniser, one flop pair per bit.
// assumes each bit is a quasi-static level; multi-bit words must be stable when sampled.
module bst_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : bst_sync

// ==== rtl/bst_tap.sv ====
// boundary-scan test access port with boundary register around the device pins.
// assumes pads report whether each test input is driven; the test clock pad has a pull-down.
// tap logic runs on test_clock_in; pin muxing runs on clk; modes cross as quasi-static levels.

module bst_tap
  import bst_pkg::*;
#(
  parameter int N_OUT = 8,
  parameter int N_IN = 8,
  // identification fields, values arbitrary
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_MFR = 11'h055
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic test_clock_in,
  input wire logic test_reset_b,
  input wire logic test_reset_driven,
  input wire logic test_mode_sel,
  input wire logic test_mode_driven,
  input wire logic test_data_in,
  input wire logic test_data_driven,
  output logic test_data_out,
  output logic test_data_out_en,
  input wire logic [N_OUT-1:0] core_out,
  output logic [N_OUT-1:0] pin_out,
  output logic [N_OUT-1:0] pin_out_en,
  input wire logic [N_IN-1:0] pin_in,
  output logic [N_IN-1:0] core_in
);
  localparam int BSR_W = N_OUT + N_IN;
  localparam logic [BST_ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, BST_ID_LSB_VAL};

  // undriven inputs fall back to the pull-up level
  logic trst_b;
  logic tms;
  logic tdi;
  assign trst_b = test_reset_driven ? test_reset_b : 1'b1;
  assign tms = test_mode_driven ? test_mode_sel : 1'b1;
  assign tdi = test_data_driven ? test_data_in : 1'b1;

  bst_state_t state_reg;
  bst_state_t state_next;
  logic [BST_IR_W-1:0] ir_sr_reg;
  logic [BST_IR_W-1:0] ir_reg;
  logic [BST_ID_W-1:0] id_sr_reg;
  logic [BSR_W-1:0] bsr_sr_reg;
  logic [BSR_W-1:0] bsr_upd_reg;
  logic byp_reg;
  logic [BSR_W-1:0] cap_sync;

  // tap sequencing
  always_comb begin
    case (state_reg)
      BST_TLR: state_next = tms ? BST_TLR : BST_RTI;
      BST_RTI: state_next = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: state_next = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: state_next = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_SHF_DR: state_next = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_EX1_DR: state_next = tms ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: state_next = tms ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: state_next = tms ? BST_UPD_DR : BST_SHF_DR;
      BST_UPD_DR: state_next = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: state_next = tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: state_next = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_SHF_IR: state_next = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_EX1_IR: state_next = tms ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: state_next = tms ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: state_next = tms ? BST_UPD_IR : BST_SHF_IR;
      BST_UPD_IR: state_next = tms ? BST_SEL_DR : BST_RTI;
      default: state_next = BST_TLR;
    endcase
  end

  always_ff @(posedge test_clock_in or negedge trst_b) begin
    if (!trst_b) begin
      state_reg <= BST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // instruction decode; anything unlisted falls to bypass
  logic sel_bsr;
  logic sel_id;
  logic mode_ext;
  logic mode_hiz;
  logic mode_clamp;
  always_comb begin
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    mode_ext = 1'b0;
    mode_hiz = 1'b0;
    mode_clamp = 1'b0;
    case (ir_reg)
      BST_IR_EXTEST: begin
        sel_bsr = 1'b1;
        mode_ext = 1'b1;
      end
      BST_IR_IDCODE: sel_id = 1'b1;
      BST_IR_SAMPLE: sel_bsr = 1'b1;
      BST_IR_HIGHZ: mode_hiz = 1'b1;
      BST_IR_CLAMP: mode_clamp = 1'b1;
      BST_IR_BYPASS: sel_bsr = 1'b0;
      default: sel_bsr = 1'b0;
    endcase
  end

  // instruction register
  always_ff @(posedge test_clock_in or negedge trst_b) begin
    if (!trst_b) begin
      ir_sr_reg <= BST_IR_CAPTURE;
    end else if (state_reg == BST_CAP_IR) begin
      ir_sr_reg <= BST_IR_CAPTURE;
    end else if (state_reg == BST_SHF_IR) begin
      ir_sr_reg <= {tdi, ir_sr_reg[BST_IR_W-1:1]};
    end
  end

  // test logic reset selects idcode so a blind scan reads the id word
  always_ff @(posedge test_clock_in or negedge trst_b) begin
    if (!trst_b) begin
      ir_reg <= BST_IR_IDCODE;
    end else if (state_reg == BST_TLR) begin
      ir_reg <= BST_IR_IDCODE;
    end else if (state_reg == BST_UPD_IR) begin
      ir_reg <= ir_sr_reg;
    end
  end

  // identification register
  always_ff @(posedge test_clock_in or negedge trst_b) begin
    if (!trst_b) begin
      id_sr_reg <= '0;
    end else if (sel_id && state_reg == BST_CAP_DR) begin
      id_sr_reg <= ID_VALUE;
    end else if (sel_id && state_reg == BST_SHF_DR) begin
      id_sr_reg <= {tdi, id_sr_reg[BST_ID_W-1:1]};
    end
  end

  // bypass bit captures zero, as the standard requires
  always_ff @(posedge test_clock_in or negedge trst_b) begin
    if (!trst_b) begin
      byp_reg <= 1'b0;
    end else if (!sel_bsr && !sel_id && state_reg == BST_CAP_DR) begin
      byp_reg <= 1'b0;
    end else if (!sel_bsr && !sel_id && state_reg == BST_SHF_DR) begin
      byp_reg <= tdi;
    end
  end

  // boundary cells: outputs in low bits, inputs above; capture from synchronised pins
  genvar gi;
  generate
    for (gi = 0; gi < BSR_W; gi++) begin : g_cell
      logic shift_in;
      if (gi == BSR_W - 1) begin : g_top
        assign shift_in = tdi;
      end else begin : g_mid
        assign shift_in = bsr_sr_reg[gi+1];
      end
      always_ff @(posedge test_clock_in or negedge trst_b) begin
        if (!trst_b) begin
          bsr_sr_reg[gi] <= 1'b0;
        end else if (sel_bsr && state_reg == BST_CAP_DR) begin
          bsr_sr_reg[gi] <= cap_sync[gi];
        end else if (sel_bsr && state_reg == BST_SHF_DR) begin
          bsr_sr_reg[gi] <= shift_in;
        end
      end
      // update latch only changes on update-dr, so preloaded values survive later instructions
      always_ff @(posedge test_clock_in or negedge trst_b) begin
        if (!trst_b) begin
          bsr_upd_reg[gi] <= 1'b0;
        end else if (sel_bsr && state_reg == BST_UPD_DR) begin
          bsr_upd_reg[gi] <= bsr_sr_reg[gi];
        end
      end
    end
  endgenerate

  // serial output on the falling edge gives the tester half a period of setup
  logic tdo_mux;
  always_comb begin
    if (state_reg == BST_SHF_IR) begin
      tdo_mux = ir_sr_reg[0];
    end else if (sel_id) begin
      tdo_mux = id_sr_reg[0];
    end else if (sel_bsr) begin
      tdo_mux = bsr_sr_reg[0];
    end else begin
      tdo_mux = byp_reg;
    end
  end

  always_ff @(negedge test_clock_in or negedge trst_b) begin
    if (!trst_b) begin
      test_data_out <= BST_TDO_RST;
      test_data_out_en <= 1'b0;
    end else begin
      test_data_out <= tdo_mux;
      test_data_out_en <= (state_reg == BST_SHF_DR) || (state_reg == BST_SHF_IR);
    end
  end

  // pins into the test clock domain for capture
  bst_sync #(.W(BSR_W)) u_cap_sync (
    .clk(test_clock_in),
    .rst_b(trst_b),
    .d({pin_in, pin_out}),
    .q(cap_sync)
  );

  // pins, modes and held values into the system clock domain; modes and held values quasi-static between updates
  logic [N_OUT+N_IN+2:0] sys_sync;
  bst_sync #(.W(N_OUT + N_IN + 3)) u_sys_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({pin_in, bsr_upd_reg[N_OUT-1:0], mode_clamp, mode_hiz, mode_ext}),
    .q(sys_sync)
  );

  // mode bits and held values move only after two equal samples in a row,
  // so a word caught mid-change or a decode glitch never reaches the pins;
  // limitation: test clock must be several system clocks slower than clk
  logic [N_OUT+2:0] mode_prev_reg;
  logic [N_OUT+2:0] mode_held_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_prev_reg <= '0;
      mode_held_reg <= '0;
    end else begin
      mode_prev_reg <= sys_sync[N_OUT+2:0];
      if (sys_sync[N_OUT+2:0] == mode_prev_reg) begin
        mode_held_reg <= mode_prev_reg;
      end
    end
  end

  logic ext_s;
  logic hiz_s;
  logic clamp_s;
  logic [N_OUT-1:0] upd_s;
  assign ext_s = mode_held_reg[0];
  assign hiz_s = mode_held_reg[1];
  assign clamp_s = mode_held_reg[2];
  assign upd_s = mode_held_reg[N_OUT+2:3];

  // pin drivers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= {N_OUT{BST_PIN_RST}};
      pin_out_en <= '0;
    end else begin
      pin_out_en <= {N_OUT{!hiz_s}};
      if (ext_s || clamp_s) begin
        pin_out <= upd_s;
      end else begin
        pin_out <= core_out;
      end
    end
  end

  // core side inputs; in every mode, extest included, the core sees the synchronised pins, not held values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_in <= '0;
    end else begin
      core_in <= sys_sync[N_OUT+N_IN+2:N_OUT+3];
    end
  end

  a_tlr_after_ones: assert property (@(posedge test_clock_in) disable iff (!trst_b)
    tms [*5] |=> state_reg == BST_TLR)
    else $error("tap not in reset after five ones");

  a_tlr_loads_id: assert property (@(posedge test_clock_in) disable iff (!trst_b)
    state_reg == BST_TLR |=> ir_reg == BST_IR_IDCODE)
    else $error("reset state did not select idcode");

  a_ir_update_load: assert property (@(posedge test_clock_in) disable iff (!trst_b)
    state_reg == BST_UPD_IR |=> ir_reg == $past(ir_sr_reg))
    else $error("instruction not loaded on update");

  a_id_capture_word: assert property (@(posedge test_clock_in) disable iff (!trst_b)
    (sel_id && state_reg == BST_CAP_DR) |=> id_sr_reg[0] == 1'b1 && id_sr_reg == ID_VALUE)
    else $error("id word not captured");

  a_bypass_delay: assert property (@(posedge test_clock_in) disable iff (!trst_b)
    (!sel_bsr && !sel_id && state_reg == BST_SHF_DR) |=> byp_reg == $past(tdi))
    else $error("bypass bit did not take data in");

  a_preload_hold: assert property (@(posedge test_clock_in) disable iff (!trst_b)
    (state_reg != BST_UPD_DR) |=> bsr_upd_reg == $past(bsr_upd_reg))
    else $error("held boundary values changed outside update");

  a_highz_floats: assert property (@(posedge clk) disable iff (!rst_b)
    hiz_s |=> pin_out_en == '0)
    else $error("outputs driven under highz");

  a_clamp_drives: assert property (@(posedge clk) disable iff (!rst_b)
    (clamp_s || ext_s) |=> pin_out == $past(upd_s))
    else $error("outputs not driven from held values");

  a_normal_path: assert property (@(posedge clk) disable iff (!rst_b)
    (!clamp_s && !ext_s) |=> pin_out == $past(core_out))
    else $error("normal path disturbed");

endmodule : bst_tap

// ==== testbench/bst_ctl_model.sv ====
// scan controller model: drives test clock, tap reset, mode select and serial data in.
// assumes the tap samples on the rising test clock and moves data out on the falling one.
module bst_ctl_model (
  output logic tck,
  output logic trst_b,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tck = 1'h0;
    trst_b = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end

  // one 160 ns test clock period; clock rests low between calls
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    #40;
    q = tdo;
    tck <= 1'h1;
    #80;
    tck <= 1'h0;
    // released line shows the inverse so a stale value cannot pass
    tdi <= ~d;
    #40;
  endtask : step

  task automatic do_reset();
    logic b;
    trst_b <= 1'h0;
    #400;
    trst_b <= 1'h1;
    #100;
    step(1'h0, 1'h0, b);
  endtask : do_reset

  // n bits lsb first from run-test-idle and back there
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = 32'h0;
    step(1'h1, 1'h0, b);
    if (ir) step(1'h1, 1'h0, b);
    step(1'h0, 1'h0, b);
    step(1'h0, 1'h0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'h1, 1'h0, b);
    step(1'h0, 1'h0, b);
  endtask : scan
endmodule : bst_ctl_model

// ==== testbench/bst_tap_tb.sv ====
// self-checking bench for the boundary-scan port.
// assumes bst_tap and bst_ctl_model; the model makes the 160 ns test clock.
module bst_tap_tb
  import bst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_EXP = {4'h1, 16'h1234, 11'h055, 1'h1};
  logic clk, rst_b, tck, trst_b, tms, tdi, tdo, tdo_en, trst_drv, tms_drv, tdi_drv;
  logic [7:0] core_out, pin_out, pin_out_en, pin_in, core_in;
  logic [31:0] o;
  int num_errors = 0;
  int checks_done = 0;
  int en_seen = 0;

  bst_tap #(.N_OUT(8), .N_IN(8), .ID_VERSION(4'h1), .ID_PART(16'h1234), .ID_MFR(11'h055)) i_bst_tap (
    .clk(clk), .rst_b(rst_b), .test_clock_in(tck), .test_reset_b(trst_b), .test_reset_driven(trst_drv),
    .test_mode_sel(tms), .test_mode_driven(tms_drv), .test_data_in(tdi), .test_data_driven(tdi_drv),
    .test_data_out(tdo), .test_data_out_en(tdo_en), .core_out(core_out), .pin_out(pin_out),
    .pin_out_en(pin_out_en), .pin_in(pin_in), .core_in(core_in));
  bst_ctl_model i_bst_ctl_model (.tck(tck), .trst_b(trst_b), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // rising test clock edges that see the serial output enabled
  always @(posedge tck) begin
    if (tdo_en === 1'h1) begin
      en_seen++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // let the edge's updates land before looking
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wclk

  task automatic load_ir(input logic [2:0] code);
    i_bst_ctl_model.scan(1'h1, 3, {29'h0, code}, o);
    chk(o & 32'h7, 32'h1, "ir capture");
    wclk(4);
  endtask : load_ir

  task automatic t_idcode();
    i_bst_ctl_model.scan(1'h0, 32, 32'h0, o);
    chk(o, ID_EXP, "id word");
    @(posedge clk);
    core_out <= 8'h96;
    wclk(3);
    chk({24'h0, pin_out}, 32'h96, "pins under id");
    chk({31'h0, tdo_en}, 32'h0, "tdo enable idle");
    chk(32'(en_seen), 32'h20, "tdo enable in shift");
  endtask : t_idcode

  task automatic t_sample();
    load_ir(BST_IR_SAMPLE);
    @(posedge clk);
    core_out <= 8'ha5;
    pin_in <= 8'h3c;
    wclk(8);
    i_bst_ctl_model.scan(1'h0, 16, 32'h5a, o);
    chk(o, 32'h3ca5, "sample capture");
    wclk(4);
    chk({24'h0, pin_out}, 32'ha5, "pins under sample");
    chk({24'h0, core_in}, 32'h3c, "core inputs");
  endtask : t_sample

  // codes with the one-bit register in the path; out lags in by one bit
  task automatic t_bypass_like();
    logic [2:0] codes [5] = '{BST_IR_BYPASS, 3'h5, 3'h6, BST_IR_HIGHZ, BST_IR_CLAMP};
    foreach (codes[k]) begin
      load_ir(codes[k]);
      i_bst_ctl_model.scan(1'h0, 8, 32'hb4, o);
      chk(o, 32'h68, "bypass path");
      chk({24'h0, pin_out_en}, (codes[k] == BST_IR_HIGHZ) ? 32'h0 : 32'hff, "pin enables");
      chk({24'h0, pin_out}, (codes[k] == BST_IR_CLAMP) ? 32'h5a : 32'ha5, "pin values");
    end
  endtask : t_bypass_like

  task automatic t_extest();
    load_ir(BST_IR_EXTEST);
    chk({24'h0, pin_out}, 32'h5a, "held preload");
    @(posedge clk);
    pin_in <= 8'hc3;
    i_bst_ctl_model.scan(1'h0, 16, 32'h81, o);
    chk((o >> 8) & 32'hff, 32'hc3, "extest capture");
    wclk(4);
    chk({24'h0, pin_out}, 32'h81, "extest drive");
  endtask : t_extest

  // undriven mode select reads high, so five clocks reach reset and ir becomes idcode
  task automatic t_undriven();
    logic b;
    @(posedge clk);
    tms_drv <= 1'h0;
    repeat (5) i_bst_ctl_model.step(1'h0, 1'h0, b);
    @(posedge clk);
    tms_drv <= 1'h1;
    i_bst_ctl_model.step(1'h0, 1'h0, b);
    i_bst_ctl_model.scan(1'h0, 32, 32'h0, o);
    chk(o, ID_EXP, "reset by undriven tms");
  endtask : t_undriven

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_b = 1'h0;
    trst_drv = 1'h1;
    tms_drv = 1'h1;
    tdi_drv = 1'h1;
    core_out = 8'h0;
    pin_in = 8'h0;
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    i_bst_ctl_model.do_reset();
    t_idcode();
    t_sample();
    t_bypass_like();
    t_extest();
    t_undriven();
    tally_and_finish();
  end

  // whole sequence needs about 41 us of test clock
  initial begin
    #600000;
    num_errors++;
    tally_and_finish();
  end
endmodule : bst_tap_tb
